// ---- src/iacc_pkg.sv ----
// Package: register map, field positions, reset values and types of the two-wire bus control block
package iacc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_OWN_ADDR = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_CTRL2 = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_DATA = 8'h10;

  // own_slave_address fields
  localparam int SA_MSB = 7;
  localparam int SA_LSB = 1;
  localparam int FFS_BIT = 0;

  // transfer_control_1 fields
  localparam int BC_LSB = 5;
  localparam int ACK_BIT = 4;
  localparam int SCK_LSB = 0;

  // transfer_control_2 fields in the upper four bits (also the status layout for all eight)
  localparam int MST_BIT = 7;
  localparam int TRX_BIT = 6;
  localparam int BB_BIT = 5;
  localparam int PIN_BIT = 4;
  localparam int AL_BIT = 3;
  localparam int AAS_BIT = 2;
  localparam int AD0_BIT = 1;
  localparam int LRB_BIT = 0;

  // Reset values
  localparam logic [7:0] OWN_ADDR_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic PIN_RST = 1'b1;

  // Serial clock half period at select 0, in system clocks; doubles per select step
  localparam logic [15:0] SCL_HALF_BASE = 16'h0010;

  // Unit length in bits when the bit count field reads zero
  localparam logic [3:0] FULL_UNIT = 4'h8;

  typedef struct packed {
    logic write;
    logic [7:0] ofs;
  } iacc_aphase_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DATA = 2'b01,
    ST_ACK = 2'b10,
    ST_HOLD = 2'b11
  } iacc_state_t;

  // Bits in one data unit for a given bit count field
  function automatic logic [3:0] unit_bits(input logic [2:0] bc);
    unit_bits = (bc == 3'h0) ? FULL_UNIT : {1'b0, bc};
  endfunction

endpackage

// ---- src/iacc_scl_gen.sv ----
// Master serial clock generator with multi-master clock synchronisation
`timescale 1ns/1ps
module iacc_scl_gen #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic en,
  input wire logic [CNT_W-1:0] half_cnt,
  // Synchronised bus clock level
  input wire logic scl_line,
  // Released (high) or pulling low
  output logic scl_high
);

  logic [CNT_W-1:0] cnt;
  logic line_q;

  if (CNT_W < 12)
  begin : g_width_check
    $error("iacc_scl_gen: counter too narrow for the slowest clock select");
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      line_q <= 1'b1;
    else
      line_q <= scl_line;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scl_high <= 1'b1;
      cnt <= '0;
    end
    else if (!en)
    begin
      scl_high <= 1'b1;
      cnt <= '0;
    end
    else if (scl_high)
    begin
      if (line_q && !scl_line)
      begin
        // Another master pulled the line low first
        scl_high <= 1'b0;
        cnt <= '0;
      end
      else if (!scl_line)
        cnt <= '0;
      else if (cnt >= half_cnt - 1'b1)
      begin
        scl_high <= 1'b0;
        cnt <= '0;
      end
      else
        cnt <= cnt + 1'b1;
    end
    else if (cnt >= half_cnt - 1'b1)
    begin
      scl_high <= 1'b1;
      cnt <= '0;
    end
    else
      cnt <= cnt + 1'b1;
  end

endmodule // iacc_scl_gen

// ---- src/iacc_i2c_ctrl.sv ----
// Two-wire bus controller: own address, acknowledge clock, bit count, clock select, roles, AHB-Lite registers
`timescale 1ns/1ps
module iacc_i2c_ctrl #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Serial clock pin, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oen,
  // Serial data pin, open drain
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oen
);

  iacc_pkg::iacc_aphase_t aph;
  iacc_pkg::iacc_state_t state;
  logic aph_valid;
  logic [7:0] own_addr;
  logic [2:0] bc;
  logic ack_mode;
  logic [2:0] sck;
  logic master_select, transmit_direction, bb, pin, al, aas, ad0, lrb;
  logic [7:0] tx_sh, rx_sh;
  logic [3:0] cnt;
  logic last_seen, addr_phase;
  logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic addr_sel, wr_en, rd_data, wr_data, wr_ctrl2, pin_set;
  logic eff_trx, receiving, addr_match, gen_call, slave_addr_phase, drop_unit, unit_done;
  logic gen_high;
  logic [CNT_W-1:0] half_cnt;

  if (CNT_W < 12)
  begin : g_width_check
    $error("iacc_i2c_ctrl: counter too narrow for the slowest clock select");
  end

  // Pin synchronisers; only the second stage and its delayed copy are read
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_q <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_q <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_q <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_q;
  assign scl_fall = !scl_s && scl_q;
  assign start_det = scl_s && scl_q && sda_q && !sda_s;
  assign stop_det = scl_s && scl_q && !sda_q && sda_s;

  // AHB-Lite: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_sel = hsel && htrans[1] && hready;
  assign wr_en = aph_valid && aph.write;
  assign rd_data = addr_sel && !hwrite && (haddr[7:0] == iacc_pkg::OFS_DATA);
  assign wr_data = wr_en && (aph.ofs == iacc_pkg::OFS_DATA);
  assign wr_ctrl2 = wr_en && (aph.ofs == iacc_pkg::OFS_CTRL2);
  // Any buffer access, or a one written to the pending bit, releases the hold
  assign pin_set = rd_data || wr_data || (wr_ctrl2 && hwdata[iacc_pkg::PIN_BIT]);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      aph_valid <= 1'b0;
      aph <= '0;
    end
    else
    begin
      aph_valid <= addr_sel;
      if (addr_sel)
        aph <= '{write: hwrite, ofs: haddr[7:0]};
    end
  end

  // Read data is captured in the address phase so it comes from a flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_sel && !hwrite)
    begin
      if (haddr[7:0] == iacc_pkg::OFS_OWN_ADDR)
        hrdata <= {24'h000000, own_addr};
      else if (haddr[7:0] == iacc_pkg::OFS_CTRL1)
        hrdata <= {24'h000000, bc, ack_mode, 1'b0, sck};
      else if (haddr[7:0] == iacc_pkg::OFS_CTRL2)
        hrdata <= {24'h000000, master_select, eff_trx, bb, pin, 4'h0};
      else if (haddr[7:0] == iacc_pkg::OFS_STATUS)
        hrdata <= {24'h000000, master_select, eff_trx, bb, pin, al, aas, ad0, lrb};
      else if (haddr[7:0] == iacc_pkg::OFS_DATA)
        hrdata <= {24'h000000, rx_sh};
      else
        hrdata <= 32'h0000_0000;
    end
  end

  // Own address register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      own_addr <= iacc_pkg::OWN_ADDR_RST;
    else if (wr_en && aph.ofs == iacc_pkg::OFS_OWN_ADDR)
      own_addr <= hwdata[7:0];
  end

  // Control 1: bit count, acknowledge mode, clock select
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bc <= iacc_pkg::CTRL1_RST[iacc_pkg::BC_LSB +: 3];
      ack_mode <= iacc_pkg::CTRL1_RST[iacc_pkg::ACK_BIT];
      sck <= iacc_pkg::CTRL1_RST[iacc_pkg::SCK_LSB +: 3];
    end
    else
    begin
      if (wr_en && aph.ofs == iacc_pkg::OFS_CTRL1)
      begin
        bc <= hwdata[iacc_pkg::BC_LSB +: 3];
        ack_mode <= hwdata[iacc_pkg::ACK_BIT];
        sck <= hwdata[iacc_pkg::SCK_LSB +: 3];
      end
      // A start on the bus clears the bit count, overriding a same-cycle write of it
      if (start_det)
        bc <= 3'h0;
    end
  end

  // Direction and address decoding
  assign eff_trx = own_addr[iacc_pkg::FFS_BIT] ? master_select : transmit_direction;
  assign slave_addr_phase = addr_phase && !master_select && !own_addr[iacc_pkg::FFS_BIT];
  assign receiving = slave_addr_phase || !eff_trx;
  assign gen_call = (rx_sh == 8'h00);
  assign addr_match = (rx_sh[7:1] == own_addr[iacc_pkg::SA_MSB:iacc_pkg::SA_LSB]) || gen_call;
  assign drop_unit = slave_addr_phase && !addr_match;
  assign unit_done = scl_fall && ((state == iacc_pkg::ST_ACK) || (state == iacc_pkg::ST_DATA && last_seen && !ack_mode));

  // Transfer sequencer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= iacc_pkg::ST_IDLE;
      cnt <= 4'h0;
      last_seen <= 1'b0;
      addr_phase <= 1'b0;
    end
    else if (stop_det)
    begin
      state <= iacc_pkg::ST_IDLE;
      addr_phase <= 1'b0;
    end
    else if (start_det)
    begin
      state <= iacc_pkg::ST_DATA;
      cnt <= 4'h0;
      last_seen <= 1'b0;
      addr_phase <= 1'b1;
    end
    else
    begin
      case (state)
        iacc_pkg::ST_IDLE:
        begin
          if (master_select && pin_set)
          begin
            state <= iacc_pkg::ST_DATA;
            cnt <= 4'h0;
            last_seen <= 1'b0;
          end
        end
        iacc_pkg::ST_DATA:
        begin
          if (scl_rise)
          begin
            cnt <= cnt + 4'h1;
            if (cnt + 4'h1 == iacc_pkg::unit_bits(bc))
              last_seen <= 1'b1;
          end
          else if (scl_fall && last_seen)
          begin
            if (drop_unit)
              state <= iacc_pkg::ST_IDLE;
            else if (ack_mode)
              state <= iacc_pkg::ST_ACK;
            else
              state <= iacc_pkg::ST_HOLD;
          end
        end
        iacc_pkg::ST_ACK:
        begin
          if (scl_fall)
            state <= iacc_pkg::ST_HOLD;
        end
        iacc_pkg::ST_HOLD:
        begin
          if (pin)
          begin
            state <= iacc_pkg::ST_DATA;
            cnt <= 4'h0;
            last_seen <= 1'b0;
            addr_phase <= 1'b0;
          end
        end
        default:
          state <= iacc_pkg::ST_IDLE;
      endcase
    end
  end

  // Shift registers: transmit moves on falling clock, receive samples on rising
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_sh <= 8'h00;
      rx_sh <= 8'h00;
    end
    else
    begin
      if (wr_data)
        tx_sh <= hwdata[7:0];
      // The first fall only opens the low period of the first bit, so the MSB stays put
      else if (state == iacc_pkg::ST_DATA && scl_fall && !last_seen && cnt != 4'h0)
        tx_sh <= {tx_sh[6:0], 1'b1};
      if (state == iacc_pkg::ST_DATA && scl_rise)
        rx_sh <= {rx_sh[6:0], sda_s};
    end
  end

  // Last received bit, including the acknowledge slot
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      lrb <= 1'b0;
    else if ((state == iacc_pkg::ST_DATA || state == iacc_pkg::ST_ACK) && scl_rise)
      lrb <= sda_s;
  end

  // Role and direction
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      master_select <= 1'b0;
      transmit_direction <= 1'b0;
    end
    else if (stop_det || (al_event()))
    begin
      master_select <= 1'b0;
      transmit_direction <= 1'b0;
    end
    else if (wr_ctrl2)
    begin
      master_select <= hwdata[iacc_pkg::MST_BIT];
      transmit_direction <= hwdata[iacc_pkg::TRX_BIT];
    end
    else if (state == iacc_pkg::ST_DATA && scl_fall && last_seen && slave_addr_phase && addr_match)
      transmit_direction <= rx_sh[0];
    else if (state == iacc_pkg::ST_ACK && scl_fall && addr_phase && master_select && !lrb)
      transmit_direction <= !rx_sh[0];
  end

  // Arbitration is lost when a released one reads back low at the rising clock
  function automatic logic al_event();
    al_event = master_select && eff_trx && !addr_phase_slave_drv() && state == iacc_pkg::ST_DATA && scl_rise && tx_sh[7] && !sda_s;
  endfunction

  function automatic logic addr_phase_slave_drv();
    addr_phase_slave_drv = 1'b0;
  endfunction

  // Status flags; hardware set wins over a same-cycle clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bb <= 1'b0;
      al <= 1'b0;
      aas <= 1'b0;
      ad0 <= 1'b0;
    end
    else
    begin
      if (start_det)
        bb <= 1'b1;
      else if (stop_det)
        bb <= 1'b0;
      if (wr_data || rd_data || wr_ctrl2)
        al <= 1'b0;
      if (al_event())
        al <= 1'b1;
      if (wr_data || rd_data)
        aas <= 1'b0;
      if (state == iacc_pkg::ST_DATA && scl_fall && last_seen && !master_select)
      begin
        if (slave_addr_phase && addr_match)
          aas <= 1'b1;
        else if (addr_phase && own_addr[iacc_pkg::FFS_BIT])
          aas <= 1'b1;
      end
      if (start_det || stop_det)
        ad0 <= 1'b0;
      else if (state == iacc_pkg::ST_DATA && scl_fall && last_seen && slave_addr_phase && gen_call)
        ad0 <= 1'b1;
    end
  end

  // Pending bit: cleared at unit end, set by buffer access or a written one
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pin <= iacc_pkg::PIN_RST;
    else if (unit_done)
      pin <= 1'b0;
    else if (pin_set)
      pin <= 1'b1;
  end

  assign half_cnt = CNT_W'(iacc_pkg::SCL_HALF_BASE) << sck;

  iacc_scl_gen #(
    .CNT_W(CNT_W)
  ) u_scl_gen (
    .hclk(hclk),
    .hresetn(hresetn),
    .en(master_select && pin && (state == iacc_pkg::ST_DATA || state == iacc_pkg::ST_ACK)),
    .half_cnt(half_cnt),
    .scl_line(scl_s),
    .scl_high(gen_high)
  );

  // Open-drain outputs: enable low means pulling the line low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      scl_oen <= 1'b1;
    else
      scl_oen <= pin && gen_high;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sda_oen <= 1'b1;
    else if (state == iacc_pkg::ST_ACK)
      sda_oen <= !(receiving && !drop_unit);
    else if ((state == iacc_pkg::ST_DATA || state == iacc_pkg::ST_HOLD) && !receiving)
      sda_oen <= tx_sh[7];
    else
      sda_oen <= 1'b1;
  end

endmodule // iacc_i2c_ctrl

// ---- bench/iacc_props.sv ----
// Port checker for the two-wire control block
`timescale 1ns/1ps
module iacc_props (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Register bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Open-drain pins
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oen,
  input wire logic sda_o,
  input wire logic sda_oen
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_UPPER_ZERO: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  AST_READ_HOLD: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  AST_OKAY_NOWAIT: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  AST_OPEN_DRAIN: assert property (!scl_o && !sda_o)
    else $error("pin drives high");
  AST_RESET_RELEASE: assert property ($rose(hresetn) |-> scl_oen && sda_oen ##1 scl_oen && sda_oen)
    else $error("pins driven after reset");
  AST_SDA_WHILE_LOW: assert property ($changed(sda_oen) |-> !scl_i)
    else $error("data line moved while clock high");
  // A high count that ran during a stretch would pull low right after the line rises
  AST_HIGH_COUNT: assert property ($fell(scl_oen) |-> !scl_i || $past(scl_i, 10))
    else $error("high period shorter than line high");
  AST_LOW_HOLD: assert property ($fell(scl_oen) |=> !scl_oen [*8])
    else $error("clock low period too short");
endmodule // iacc_props

bind iacc_i2c_ctrl iacc_props props_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scl_i(scl_i),
  .scl_o(scl_o), .scl_oen(scl_oen), .sda_o(sda_o), .sda_oen(sda_oen));

// ---- bench/iacc_bus_party.sv ----
// Behavioural far party on the two-wire bus: master tasks and an acking, stretching slave
`timescale 1ns/1ps
module iacc_bus_party (
  // Wired bus levels
  input wire logic scl_line,
  input wire logic sda_line,
  // Enables, low pulls the line
  output logic scl_oen,
  output logic sda_oen
);
  int falls = 0;
  int ack_at = 0;
  int stretch_at = 0;

  initial
  begin
    scl_oen = 1'b1;
    sda_oen = 1'b1;
  end

  // Slave side only while a scenario arms it, so master tasks keep their own data line
  always @(negedge scl_line)
  begin
    if (ack_at != 0 || stretch_at != 0)
    begin
      falls = falls + 1;
      sda_oen = (falls != ack_at);
      if (falls == stretch_at)
      begin
        scl_oen = 1'b0;
        #2000 scl_oen = 1'b1;
      end
    end
  end

  task automatic bit_io(input logic b, output logic s);
    sda_oen = b;
    #80 scl_oen = 1'b1;
    wait (scl_line);
    #80 s = sda_line;
    scl_oen = 1'b0;
  endtask

  task automatic start();
    sda_oen = 1'b0;
    #80 scl_oen = 1'b0;
    #80;
  endtask

  task automatic stop();
    sda_oen = 1'b0;
    #80 scl_oen = 1'b1;
    wait (scl_line);
    #80 sda_oen = 1'b1;
    #160;
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, ack);
  endtask
endmodule // iacc_bus_party

// ---- bench/iacc_i2c_ctrl_tb.sv ----
// Self-checking bench for the two-wire control block
`timescale 1ns/1ps
module iacc_i2c_ctrl_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, scl_o, sda_o, dut_scl_oen, dut_sda_oen, p_scl_oen, p_sda_oen, ack, ack_oen;
  logic [31:0] hrdata, rd;
  logic [8:0] rx;
  int rises, fails, num_checks;
  logic [7:0] r_ofs [4] = '{8'h00, 8'h00, 8'h04, 8'h20};
  logic [31:0] r_wd [4] = '{32'hffffffff, 32'h000000a5, 32'h000000f7, 32'h000000ff};
  logic [31:0] r_ex [4] = '{32'h000000ff, 32'h000000a5, 32'h000000f7, 32'h00000000};
  // Wired AND with pull-ups
  wire logic scl_line = dut_scl_oen & p_scl_oen;
  wire logic sda_line = dut_sda_oen & p_sda_oen;

  iacc_i2c_ctrl #(.CNT_W(16)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .scl_i(scl_line), .scl_o(scl_o), .scl_oen(dut_scl_oen), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oen(dut_sda_oen));
  iacc_bus_party party_u (.scl_line(scl_line), .sda_line(sda_line), .scl_oen(p_scl_oen), .sda_oen(p_sda_oen));

  always #5 hclk = ~hclk;

  always @(posedge scl_line)
  begin
    rises++;
    rx = {rx[7:0], sda_line};
    if (rises == 9)
      ack_oen = dut_sda_oen;
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, ofs};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic rchk(input string nm, input logic [7:0] ofs, input logic [31:0] m, e);
    logic [31:0] r;
    bus(1'b0, ofs, 32'h0, r);
    check(nm, r & m, e);
  endtask

  task automatic wait_pin();
    logic [31:0] s = 32'h10;
    int n = 0;
    while (s[4] === 1'b1 && n < 2000)
    begin
      bus(1'b0, 8'h0c, 32'h0, s);
      n++;
    end
    check("unit done", s & 32'h10, 32'h0);
  endtask

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #500000;
    fails++;
    give_verdict();
  end

  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    check("pins at reset", {30'h0, dut_scl_oen, dut_sda_oen}, 32'h3);
    rchk("own addr reset", 8'h00, 32'hffffffff, 32'h0);
    rchk("ctrl1 reset", 8'h04, 32'hffffffff, 32'h0);
    rchk("status reset", 8'h0c, 32'hffffffff, 32'h10);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, r_ofs[i], r_wd[i], rd);
      rchk("row readback", r_ofs[i], 32'hffffffff, r_ex[i]);
    end
    // Master transmit, ack mode, far slave stretches mid-unit
    bus(1'b1, 8'h04, 32'h00000013, rd);
    bus(1'b1, 8'h08, 32'h000000c0, rd);
    party_u.falls = 0;
    party_u.ack_at = 9;
    party_u.stretch_at = 3;
    rises = 0;
    bus(1'b1, 8'h10, 32'h000000a5, rd);
    wait_pin();
    check("unit clocks", rises, 9);
    check("tx bits", {23'h0, rx}, 32'h0000014a);
    check("ack release", {31'h0, ack_oen}, 32'h1);
    rchk("master status", 8'h0c, 32'h000000d1, 32'h000000c0);
    // Three-bit unit without ack clock
    party_u.ack_at = 0;
    party_u.stretch_at = 0;
    rises = 0;
    bus(1'b1, 8'h04, 32'h00000063, rd);
    bus(1'b1, 8'h10, 32'h000000a5, rd);
    wait_pin();
    check("short unit clocks", rises, 3);
    check("short unit bits", {29'h0, rx[2:0]}, 32'h5);
    bus(1'b1, 8'h08, 32'h00000010, rd);
    // Slave with address recognition
    bus(1'b1, 8'h00, 32'h000000a4, rd);
    bus(1'b1, 8'h04, 32'h00000070, rd);
    party_u.start();
    rchk("busy on start", 8'h0c, 32'h20, 32'h20);
    rchk("count forced", 8'h04, 32'hff, 32'h10);
    party_u.send_byte(8'ha4, ack);
    check("match ack", {31'h0, ack}, 32'h0);
    rchk("addressed", 8'h0c, 32'h44, 32'h04);
    bus(1'b0, 8'h10, 32'h0, rd);
    party_u.stop();
    rchk("free on stop", 8'h0c, 32'h20, 32'h0);
    party_u.start();
    party_u.send_byte(8'ha6, ack);
    check("other addr nack", {31'h0, ack}, 32'h1);
    party_u.stop();
    // Stop on the bus ends the master role
    bus(1'b1, 8'h08, 32'h00000080, rd);
    rchk("master set", 8'h0c, 32'h80, 32'h80);
    party_u.start();
    party_u.stop();
    rchk("stop clears master", 8'h0c, 32'ha0, 32'h0);
    // Free data format fixes the direction
    bus(1'b1, 8'h00, 32'h00000001, rd);
    bus(1'b1, 8'h08, 32'h00000080, rd);
    rchk("free master tx", 8'h0c, 32'hc0, 32'hc0);
    bus(1'b1, 8'h08, 32'h00000040, rd);
    rchk("free slave rx", 8'h0c, 32'hc0, 32'h0);
    give_verdict();
  end
endmodule // iacc_i2c_ctrl_tb
